// ==== rtl/dct_params.svh ====
// Constants of the dual channel timer: offsets, fields, reset values.
// Assumes inclusion by bare name from the timer module.
`ifndef DCT_PARAMS_SVH
`define DCT_PARAMS_SVH
// Register byte offsets inside one channel window
`define DCT_OFF_CTRL 4'h0
`define DCT_OFF_PERIOD 4'h4
`define DCT_OFF_COUNT 4'h8
// Interrupt status and mask word offsets
`define DCT_OFF_IRQ_STAT 5'h0c
`define DCT_OFF_IRQ_MASK 5'h1c
// Channel window stride select bit of haddr
`define DCT_CHAN_BIT 4
// Control field positions
`define DCT_CTRL_OUTPUT_PIN_FUNCTION_BIT 0
`define DCT_CTRL_DOUT 1
`define DCT_CTRL_DATIN 3
`define DCT_CTRL_CLKMODE 4
`define DCT_CTRL_RESTART 6
`define DCT_CTRL_HOLDREL 7
`define DCT_CTRL_CLKSRC 9
`define DCT_CTRL_STAT 11
// Writable control bits
`define DCT_CTRL_WMASK 32'h0000_0293
// Reset values
`define DCT_CTRL_RST 32'h0000_0000
`define DCT_PERIOD_RST 32'h0000_0000
`define DCT_COUNT_RST 32'h0000_0000
`endif

// ==== rtl/dct_pkg.sv ====
// Types shared by the dual channel timer.
// Assumes the params header is on the include path.
package dct_pkg;
    typedef logic [31:0] dct_word_t;
    typedef enum logic [1:0] {
        DCT_HTRANS_IDLE = 2'h0,
        DCT_HTRANS_BUSY = 2'h1,
        DCT_HTRANS_NONSEQ = 2'h2,
        DCT_HTRANS_SEQ = 2'h3
    } dct_htrans_t;
endpackage : dct_pkg

// ==== rtl/dct_dual_timer.sv ====
// Two-channel timer with AHB-Lite register slave and interrupt.
// Assumes one clock ref_clk, sync active-low reset, a single master.
// Operation
// - Two independent channels, each own registers, pins
// - Restart with hold-release clears and starts
// - Hold-release clear freezes the counter
// - Hold-release set alone resumes from held
// - Clock source internal or external pin
// - Output mode pulse or clock
// - Control, period, counter reset to zero
// - Counter write loads running count
// - Counter read returns current count
// - Period register read/write holds limit
// - Input pin level readable by software
// - Function bit makes output software-driven
`timescale 1ns/1ps
`include "dct_params.svh"
module dct_dual_timer #(
    parameter int NUM_CHAN = 2,
    parameter int INT_DIV = 4
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire dct_pkg::dct_htrans_t htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire dct_pkg::dct_word_t hwdata,
    output dct_pkg::dct_word_t hrdata,
    output logic hreadyout,
    output logic hresp,
    // Timer pins
    input wire logic [1:0] timerInPin,
    output logic [1:0] timerOutPin,
    // Interrupt
    output logic irq
);
    import dct_pkg::*;

    // Elaboration check: two channels, a divider that fits 16 bits
    if (NUM_CHAN != 2 || INT_DIV < 1 || INT_DIV > 65535) begin : g_bad_param
        $error("dct_dual_timer: unsupported parameters");
    end

    // Address phase capture
    logic wrPend_r;
    logic rdSel;
    logic [4:0] wrAddr_r;
    logic [1:0] wrEvt;
    logic [1:0] ctrlWr;
    logic [1:0] perWr;
    logic [1:0] cntWr;
    logic statWr;
    logic maskWr;
    logic inWin;
    assign rdSel = hsel && hready && htrans[1] && !hwrite;
    // Only the first eight words are mapped; the rest read zero
    assign inWin = (haddr[31:5] == 27'h000_0000);

    // Write pending register for the data phase
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wrPend_r <= 1'b0;
            wrAddr_r <= 5'h00;
        end else if (hready) begin
            wrPend_r <= hsel && htrans[1] && hwrite && inWin;
            wrAddr_r <= haddr[4:0];
        end
    end

    // Decode of the pending write
    // Bit four of the offset picks the channel window
    always_comb begin
        statWr = wrPend_r && (wrAddr_r == `DCT_OFF_IRQ_STAT);
        maskWr = wrPend_r && (wrAddr_r == `DCT_OFF_IRQ_MASK);
        for (int c = 0; c < 2; c++) begin
            ctrlWr[c] = wrPend_r && (wrAddr_r[`DCT_CHAN_BIT] == c[0])
                && (wrAddr_r[3:0] == `DCT_OFF_CTRL)
                && !(wrAddr_r[3] && wrAddr_r[4]);
            perWr[c] = wrPend_r && (wrAddr_r[`DCT_CHAN_BIT] == c[0])
                && (wrAddr_r[3:0] == `DCT_OFF_PERIOD)
                && !(wrAddr_r[3] && wrAddr_r[4]);
            cntWr[c] = wrPend_r && (wrAddr_r[`DCT_CHAN_BIT] == c[0])
                && (wrAddr_r[3:0] == `DCT_OFF_COUNT);
        end
    end

    // Per-channel state
    logic [31:0] ctrl_r [2];
    logic [31:0] period_r [2];
    logic [31:0] count_r [2];
    logic [1:0] restart;
    // Input pin path
    logic [2:0] inSync_r [2];
    logic [1:0] inLvl;
    logic [1:0] extTick;
    // Tick sources and wrap events
    logic [15:0] divCnt_r;
    logic intTick;
    logic [1:0] tick;
    logic [1:0] wrap;
    // Output shaping
    logic [1:0] pulse_r;
    logic [1:0] clkOut_r;
    logic [1:0] tmrOut;

    // Shared internal tick divider
    // One tick every INT_DIV clocks, for both channels
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            divCnt_r <= 16'h0000;
        end else if (divCnt_r == 16'(INT_DIV - 1)) begin
            divCnt_r <= 16'h0000;
        end else begin
            divCnt_r <= divCnt_r + 16'h0001;
        end
    end
    assign intTick = (divCnt_r == 16'(INT_DIV - 1));

    // One channel slice per generate pass
    for (genvar c = 0; c < 2; c++) begin : g_chan
        // Input synchroniser; stage 0 feeds only stage 1
        // Three stages keep a metastable level away
        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                inSync_r[c] <= 3'h0;
            end else begin
                inSync_r[c] <= {inSync_r[c][1:0], timerInPin[c]};
            end
        end
        // Accepted level changes when stages one and two agree
        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                inLvl[c] <= 1'b0;
            end else if (inSync_r[c][1] == inSync_r[c][2]) begin
                inLvl[c] <= inSync_r[c][2];
            end
        end
        // Rising edge of the accepted input level
        assign extTick[c] = (inSync_r[c][1] == inSync_r[c][2])
            && inSync_r[c][2] && !inLvl[c];
        // Count clock pick, internal divider or pin
        assign tick[c] = ctrl_r[c][`DCT_CTRL_CLKSRC]
            ? intTick : extTick[c];
        // Restart needs both control bits in one write
        assign restart[c] = ctrlWr[c] && hwdata[`DCT_CTRL_RESTART]
            && hwdata[`DCT_CTRL_HOLDREL];
        // Wrap when the count has reached the period
        assign wrap[c] = tick[c] && ctrl_r[c][`DCT_CTRL_HOLDREL]
            && (count_r[c] >= period_r[c]);

        // Control register; restart bit reads back zero
        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                ctrl_r[c] <= `DCT_CTRL_RST;
            end else if (ctrlWr[c]) begin
                ctrl_r[c] <= hwdata & `DCT_CTRL_WMASK;
            end
        end

        // Period register
        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                period_r[c] <= `DCT_PERIOD_RST;
            end else if (perWr[c]) begin
                period_r[c] <= hwdata;
            end
        end

        // Counter: load, restart, hold, advance and wrap
        // Restart beats a load, a load beats a cleared hold; otherwise a cleared hold freezes the count
        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                count_r[c] <= `DCT_COUNT_RST;
            end else if (restart[c]) begin
                count_r[c] <= 32'h0000_0000;
            end else if (cntWr[c]) begin
                count_r[c] <= hwdata;
            end else if (!ctrl_r[c][`DCT_CTRL_HOLDREL]) begin
                count_r[c] <= count_r[c];
            end else if (wrap[c]) begin
                count_r[c] <= 32'h0000_0000;
            end else if (tick[c]) begin
                count_r[c] <= count_r[c] + 32'h0000_0001;
            end
        end

        // Output event shaping: one-cycle pulse or toggling clock
        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                pulse_r[c] <= 1'b0;
                clkOut_r[c] <= 1'b0;
            end else begin
                pulse_r[c] <= wrap[c];
                if (restart[c]) begin
                    clkOut_r[c] <= 1'b0;
                end else if (wrap[c]) begin
                    clkOut_r[c] <= !clkOut_r[c];
                end
            end
        end
        assign tmrOut[c] = ctrl_r[c][`DCT_CTRL_CLKMODE]
            ? clkOut_r[c] : pulse_r[c];

        // Output pin, timer or software level
        // Registered so the pin never glitches
        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                timerOutPin[c] <= 1'b0;
            end else begin
                timerOutPin[c] <= ctrl_r[c][`DCT_CTRL_OUTPUT_PIN_FUNCTION_BIT]
                    ? ctrl_r[c][`DCT_CTRL_DOUT] : tmrOut[c];
            end
        end
    end

    // Interrupt status and mask, sticky wrap events
    logic [1:0] irqStat_r;
    logic [1:0] irqMask_r;
    logic [1:0] irqClr;
    // Write-one-to-clear bits of the status word
    assign irqClr = statWr ? hwdata[1:0] : 2'h0;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            irqStat_r <= 2'h0;
        end else begin
            // Set wins over a write-one clear
            irqStat_r <= (irqStat_r & ~irqClr) | wrap;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            irqMask_r <= 2'h0;
        end else if (maskWr) begin
            irqMask_r <= hwdata[1:0];
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStat_r & irqMask_r);
        end
    end

    // Read mux, registered at the address phase
    // Control word as read, with live input and status bits
    function automatic logic [31:0] ctrlView(input int ch);
        logic [31:0] v;
        v = ctrl_r[ch];
        v[`DCT_CTRL_DATIN] = inLvl[ch];
        v[`DCT_CTRL_STAT] = timerOutPin[ch];
        return v;
    endfunction : ctrlView

    logic [31:0] rdMux;
    always_comb begin
        rdMux = 32'h0000_0000;
        case (haddr[4:0])
            {1'b0, `DCT_OFF_CTRL}: rdMux = ctrlView(0);
            {1'b0, `DCT_OFF_PERIOD}: rdMux = period_r[0];
            {1'b0, `DCT_OFF_COUNT}: rdMux = count_r[0];
            `DCT_OFF_IRQ_STAT: rdMux = {30'h0, irqStat_r};
            {1'b1, `DCT_OFF_CTRL}: rdMux = ctrlView(1);
            {1'b1, `DCT_OFF_PERIOD}: rdMux = period_r[1];
            {1'b1, `DCT_OFF_COUNT}: rdMux = count_r[1];
            `DCT_OFF_IRQ_MASK: rdMux = {30'h0, irqMask_r};
            default: rdMux = 32'h0000_0000;
        endcase
        // Offsets outside the window read as zero
        if (!inWin) begin
            rdMux = 32'h0000_0000;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            hrdata <= 32'h0000_0000;
        end else if (rdSel) begin
            hrdata <= rdMux;
        end
    end

    // Zero-wait slave, always OKAY
    // Registered so the bus outputs come from flip-flops
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

endmodule : dct_dual_timer

// ==== bench/dct_pin_drv.sv ====
// External source on the timer input pins.
// Assumes the bench enables toggling per channel.
`timescale 1ns/1ps
module dct_pin_drv #(
    parameter int HALF = 3
) (
    // Clock and control
    input wire logic ref_clk,
    input wire logic [1:0] genEn,
    // Pins into the timer
    output logic [1:0] timerInPin
);
    int cnt = 0;
    initial timerInPin = 2'h0;
    // Toggle enabled pins every HALF cycles, else hold the level
    always @(posedge ref_clk) begin
        cnt <= (cnt + 1) % HALF;
        if (cnt == 0) begin
            timerInPin <= timerInPin ^ genEn;
        end
    end
endmodule : dct_pin_drv

// ==== bench/dct_timer_props.sv ====
// Port assertions of the dual channel timer.
// Assumes the bind below onto the timer top module.
`timescale 1ns/1ps
module dct_timer_props (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire dct_pkg::dct_htrans_t htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire dct_pkg::dct_word_t hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Pins
    input wire logic [1:0] timerInPin,
    input wire logic [1:0] timerOutPin,
    input wire logic irq
);
    import dct_pkg::*;
    logic take;
    logic anyWr_r;
    logic prevIn_r;
    logic [3:0] stab_r;
    assign take = hsel && hready && htrans == DCT_HTRANS_NONSEQ;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // First write seen, and stability count of input pin 0
    always_ff @(posedge ref_clk) begin
        anyWr_r <= rst_n && (anyWr_r || (take && hwrite));
        prevIn_r <= timerInPin[0];
        if (!rst_n || timerInPin[0] != prevIn_r) begin
            stab_r <= 4'h0;
        end else if (stab_r != 4'hf) begin
            stab_r <= stab_r + 4'h1;
        end
    end
    sequence s_rdCtrl0;
        take && !hwrite && haddr == 32'h0000_0000;
    endsequence
    sequence s_rdCtrl;
        take && !hwrite
            && (haddr == 32'h0000_0000 || haddr == 32'h0000_0010);
    endsequence
    a_ready_high: assert property (hreadyout)
        else $error("ready low");
    a_resp_okay: assert property (!hresp)
        else $error("error response");
    a_reset_clears: assert property ($rose(rst_n) |->
        hrdata == 32'h0 && timerOutPin == 2'h0 && !irq)
        else $error("outputs not cleared");
    a_quiet_till_write: assert property (!anyWr_r |->
        timerOutPin == 2'h0 && !irq) else $error("pin before config");
    a_rdata_holds: assert property (!(take && !hwrite) |=>
        $stable(hrdata)) else $error("read data moved");
    a_ctrl_reserved: assert property (s_rdCtrl |=>
        (hrdata & ~32'h0000_0a9b) == 32'h0) else $error("ctrl bits");
    a_stat_output: assert property (s_rdCtrl0 |=>
        hrdata[11] == $past(timerOutPin[0])) else $error("status");
    a_input_level: assert property (s_rdCtrl0 |=>
        stab_r != 4'hf || hrdata[3] == timerInPin[0]) else $error("input");
endmodule : dct_timer_props
bind dct_dual_timer dct_timer_props u_props (.ref_clk, .rst_n, .hsel,
    .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
    .timerInPin, .timerOutPin, .irq);

// ==== bench/tb_top.sv ====
// Bench for the dual channel timer through AHB-Lite calls.
// Assumes the pin source model and the bound checker.
`timescale 1ns/1ps
module tb_top;
    import dct_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    dct_htrans_t htrans = DCT_HTRANS_IDLE;
    dct_word_t hwdata = 32'h0;
    dct_word_t hrdata, r, c1, c2;
    logic hreadyout, hresp, irq;
    logic [1:0] timerInPin, timerOutPin;
    logic [1:0] genEn = 2'h0;
    int nMismatch = 0;
    int totalChecks = 0;
    int cyc = 0;
    int rises, highs;
    always #12.5 ref_clk = ~ref_clk;
    dct_dual_timer #(.NUM_CHAN(2), .INT_DIV(4)) uut (.ref_clk, .rst_n,
        .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hready(hreadyout),
        .hwdata, .hrdata, .hreadyout, .hresp, .timerInPin, .timerOutPin,
        .irq);
    dct_pin_drv #(.HALF(3)) src (.ref_clk, .genEn, .timerInPin);
    // One single transfer; read data lands in r
    task automatic xfer(input logic w, input dct_word_t a, d);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= DCT_HTRANS_NONSEQ;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= DCT_HTRANS_IDLE;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : xfer
    task automatic chk(input dct_word_t exp, got);
        totalChecks++;
        if (got !== exp) begin
            nMismatch++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk
    // Count rises and high cycles of one pin over n cycles
    task automatic watch(input int ch, n, input logic inp);
        logic p = 1'b0;
        logic v;
        rises = 0;
        highs = 0;
        repeat (n) begin
            @(posedge ref_clk);
            v = inp ? timerInPin[ch] : timerOutPin[ch];
            rises += int'(v && !p);
            highs += int'(v);
            p = v;
        end
    endtask : watch
    task automatic results;
        $display("checks %0d mismatches %0d", totalChecks, nMismatch);
        if (nMismatch == 0 && totalChecks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results
    // Hang guard
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            nMismatch++;
            results();
        end
    end
    initial begin
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 32'h1c; a += 4) begin
            if (a != 12) xfer(0, a, 0);
            if (a != 12) chk(0, r);
        end
        xfer(1, 32'h04, 32'h1234_5678);
        xfer(1, 32'h14, 32'h0000_00ff);
        xfer(1, 32'h18, 32'h0000_0005);
        xfer(0, 32'h04, 0);
        chk(32'h1234_5678, r);
        xfer(0, 32'h14, 0);
        chk(32'h0000_00ff, r);
        xfer(0, 32'h18, 0);
        chk(5, r);
        xfer(0, 32'h08, 0);
        chk(0, r);
        $display("test registers done");
        xfer(1, 32'h04, 32'h100);
        xfer(1, 32'h00, 32'h2c0);
        repeat (40) @(posedge ref_clk);
        xfer(1, 32'h00, 32'h200);
        xfer(0, 32'h08, 0);
        c1 = r;
        chk(1, c1 > 7 && c1 < 32'h20);
        repeat (20) @(posedge ref_clk);
        xfer(0, 32'h08, 0);
        chk(c1, r);
        xfer(1, 32'h00, 32'h280);
        repeat (20) @(posedge ref_clk);
        xfer(0, 32'h08, 0);
        chk(1, r > c1);
        xfer(1, 32'h00, 32'h2c0);
        xfer(0, 32'h08, 0);
        chk(1, r < 4);
        xfer(1, 32'h00, 32'h200);
        xfer(1, 32'h08, 32'h40);
        xfer(0, 32'h08, 0);
        chk(32'h40, r);
        $display("test internal count done");
        xfer(1, 32'h14, 2);
        xfer(1, 32'h10, 32'h2d0);
        watch(1, 80, 0);
        chk(1, rises >= 2 && highs > rises);
        xfer(1, 32'h10, 32'h2c0);
        // Let the last clock-mode level leave the pin
        repeat (2) @(posedge ref_clk);
        watch(1, 80, 0);
        chk(1, rises >= 2 && highs == rises);
        xfer(0, 32'h18, 0);
        chk(1, r <= 2);
        xfer(1, 32'h10, 32'h210);
        xfer(0, 32'h10, 0);
        chk(timerOutPin[1], r[11]);
        $display("test output modes done");
        xfer(1, 32'h00, 32'h0c0);
        genEn <= 2'h1;
        watch(0, 60, 1);
        c2 = rises;
        genEn <= 2'h0;
        watch(0, 10, 1);
        xfer(0, 32'h08, 0);
        chk(c2 + rises, r);
        xfer(0, 32'h00, 0);
        chk(timerInPin[0], r[3]);
        $display("test external clock done");
        xfer(1, 32'h00, 32'h3);
        xfer(0, 32'h00, 0);
        chk(1, timerOutPin[0]);
        chk(1, r[11]);
        xfer(1, 32'h00, 32'h1);
        xfer(0, 32'h00, 0);
        chk(0, timerOutPin[0]);
        xfer(0, 32'h0c, 0);
        chk(1, r[1]);
        xfer(1, 32'h1c, 32'h2);
        xfer(0, 32'h1c, 0);
        chk(2, r);
        chk(1, irq);
        xfer(1, 32'h1c, 0);
        xfer(0, 32'h20, 0);
        chk(0, r);
        chk(0, irq);
        xfer(1, 32'h0c, 32'h3);
        xfer(0, 32'h0c, 0);
        chk(0, r);
        $display("test pin and interrupt done");
        results();
    end
endmodule : tb_top
